// File: bst_ctrl_model.sv
// scan controller model: test clock, mode select, data input, test reset
module bst_ctrl_model (
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi,
   output logic      o_trst,
   input  wire logic i_tdo,
   input  wire logic i_tdo_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****
   // pin driving
   // ****
   wire logic pin = i_tdo_oe ? i_tdo : 1'bz;
   // test clock stands low between frames
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
      o_trst = 1'b0;
   end
   task automatic clk(input logic tms, input logic tdi, output logic tdo);
      o_tms = tms;
      o_tdi = tdi;
      #6 o_tck = 1'b1;
      tdo = pin;
      #6 o_tck = 1'b0;
   endtask
   task automatic set_trst(input logic v);
      o_trst = v;
   endtask
   task automatic tap_reset();
      logic d;
      o_trst = 1'b0;
      #30 o_trst = 1'b1;
      clk(1'b1, 1'b1, d);
      clk(1'b0, 1'b1, d);
   endtask
   task automatic scan(input logic ir, input int n, input logic [31:0] di, output logic [31:0] q);
      logic d;
      q = '0;
      clk(1'b1, 1'b1, d);
      if (ir) begin
         clk(1'b1, 1'b1, d);
      end
      clk(1'b0, 1'b1, d);
      clk(1'b0, 1'b1, d);
      for (int i = 0; i < n; i++) begin
         clk(i == n - 1, di[i], d);
         q[i] = d;
      end
      clk(1'b1, 1'b1, d);
      clk(1'b0, 1'b1, d);
   endtask
endmodule

// File: bst_pkg.sv
// package: tap states, instruction codes, register widths and reset values
package bst_pkg;

   // ****************************************
   // tap controller states
   // ****************************************
   typedef enum logic [3:0] {
      BST_TLR  = 4'h0,
      BST_RTI  = 4'h1,
      BST_SDRS = 4'h2,
      BST_CDR  = 4'h3,
      BST_SDR  = 4'h4,
      BST_E1DR = 4'h5,
      BST_PDR  = 4'h6,
      BST_E2DR = 4'h7,
      BST_UDR  = 4'h8,
      BST_SIRS = 4'h9,
      BST_CIR  = 4'hA,
      BST_SIR  = 4'hB,
      BST_E1IR = 4'hC,
      BST_PIR  = 4'hD,
      BST_E2IR = 4'hE,
      BST_UIR  = 4'hF
   } bst_state_t;

   // ****************************************
   // instruction register
   // ****************************************
   localparam int         IR_W        = 4;
   localparam logic [3:0] IR_BYPASS   = 4'hF;
   localparam logic [3:0] IR_IDCODE   = 4'h1;
   localparam logic [3:0] IR_USER     = 4'h2;
   localparam logic [3:0] IR_CAPTURE  = 4'h1;
   localparam logic [3:0] IR_RST_VAL  = IR_IDCODE;

   // ****************************************
   // data registers
   // ****************************************
   localparam int          ID_W       = 32;
   // identity value is arbitrary
   localparam logic [31:0] ID_VAL     = 32'h0000_1001;
   localparam int          USER_W     = 16;
   localparam logic [15:0] USER_RST   = 16'h0000;
   localparam int          SYNC_DEPTH = 2;

endpackage

// File: bst_sync.sv
// two-flop level synchroniser into the system clock domain
module bst_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta <= '0;
         o_q  <= '0;
      end else begin
         meta <= i_d;
         o_q  <= meta;
      end
   end
endmodule

// File: bst_tap.sv
// boundary scan test access port with output disable control

// How it works
// - tms and tdi are sampled into state machine and registers on rising tck.
// - tdo output changes only on falling tck edges, or when test reset low clears it.
// - tdo driven only during shift-ir or shift-dr, else high impedance.
// - global output disable forces tdo to high impedance regardless of scan.
// - scan control granted only while test reset is high.
// - test reset low, line a high, line b low enters output disable.
module bst_tap #(
   parameter int          USER_WIDTH = bst_pkg::USER_W,
   parameter logic [31:0] ID_CODE    = bst_pkg::ID_VAL
) (
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst,
   input  wire logic                  i_tck,
   input  wire logic                  i_tms,
   input  wire logic                  i_tdi,
   input  wire logic                  i_trst,
   input  wire logic                  i_emulator_line_a,
   input  wire logic                  i_emulator_line_b_or_disable,
   input  wire logic [USER_WIDTH-1:0] i_user_capture,
   output logic                       o_tdo,
   output logic                       o_tdo_oe,
   output logic                       o_outputs_off,
   output logic [USER_WIDTH-1:0]      o_user_data,
   output logic                       o_user_update
);

   // ****************************************
   // tap state machine (tck domain)
   // ****************************************
   bst_pkg::bst_state_t state;
   bst_pkg::bst_state_t next_state;

   // trst low holds the machine in reset without tck running
   always_ff @(posedge i_tck or negedge i_trst) begin
      if (!i_trst) begin
         state <= bst_pkg::BST_TLR;
      end else begin
         state <= next_state;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         bst_pkg::BST_TLR:  next_state = i_tms ? bst_pkg::BST_TLR  : bst_pkg::BST_RTI;
         bst_pkg::BST_RTI:  next_state = i_tms ? bst_pkg::BST_SDRS : bst_pkg::BST_RTI;
         bst_pkg::BST_SDRS: next_state = i_tms ? bst_pkg::BST_SIRS : bst_pkg::BST_CDR;
         bst_pkg::BST_CDR:  next_state = i_tms ? bst_pkg::BST_E1DR : bst_pkg::BST_SDR;
         bst_pkg::BST_SDR:  next_state = i_tms ? bst_pkg::BST_E1DR : bst_pkg::BST_SDR;
         bst_pkg::BST_E1DR: next_state = i_tms ? bst_pkg::BST_UDR  : bst_pkg::BST_PDR;
         bst_pkg::BST_PDR:  next_state = i_tms ? bst_pkg::BST_E2DR : bst_pkg::BST_PDR;
         bst_pkg::BST_E2DR: next_state = i_tms ? bst_pkg::BST_UDR  : bst_pkg::BST_SDR;
         bst_pkg::BST_UDR:  next_state = i_tms ? bst_pkg::BST_SDRS : bst_pkg::BST_RTI;
         bst_pkg::BST_SIRS: next_state = i_tms ? bst_pkg::BST_TLR  : bst_pkg::BST_CIR;
         bst_pkg::BST_CIR:  next_state = i_tms ? bst_pkg::BST_E1IR : bst_pkg::BST_SIR;
         bst_pkg::BST_SIR:  next_state = i_tms ? bst_pkg::BST_E1IR : bst_pkg::BST_SIR;
         bst_pkg::BST_E1IR: next_state = i_tms ? bst_pkg::BST_UIR  : bst_pkg::BST_PIR;
         bst_pkg::BST_PIR:  next_state = i_tms ? bst_pkg::BST_E2IR : bst_pkg::BST_PIR;
         bst_pkg::BST_E2IR: next_state = i_tms ? bst_pkg::BST_UIR  : bst_pkg::BST_SIR;
         bst_pkg::BST_UIR:  next_state = i_tms ? bst_pkg::BST_SDRS : bst_pkg::BST_RTI;
         default:           next_state = bst_pkg::BST_TLR;
      endcase
   end

   // ****************************************
   // instruction and data registers
   // ****************************************
   logic [bst_pkg::IR_W-1:0] ir_shift;
   logic [bst_pkg::IR_W-1:0] ir;
   logic [bst_pkg::ID_W-1:0] id_shift;
   logic [USER_WIDTH-1:0]    user_shift;
   logic [USER_WIDTH-1:0]    user_reg;
   logic                     bypass_bit;
   logic                     user_tgl;
   logic [USER_WIDTH-1:0]    user_capture_m;
   logic [USER_WIDTH-1:0]    user_capture_q;

   wire sel_id   = (ir == bst_pkg::IR_IDCODE);
   wire sel_user = (ir == bst_pkg::IR_USER);
   wire in_sir   = (state == bst_pkg::BST_SIR);
   wire in_sdr   = (state == bst_pkg::BST_SDR);
   wire in_tlr   = (state == bst_pkg::BST_TLR);

   always_ff @(posedge i_tck or negedge i_trst) begin
      if (!i_trst) begin
         ir_shift   <= bst_pkg::IR_CAPTURE;
         ir         <= bst_pkg::IR_RST_VAL;
         id_shift   <= '0;
         user_shift <= '0;
         user_reg   <= '0;
         bypass_bit <= 1'b0;
         user_tgl   <= 1'b0;
      end else begin
         if (in_tlr) begin
            ir <= bst_pkg::IR_RST_VAL;
         end
         if (state == bst_pkg::BST_CIR) begin
            ir_shift <= bst_pkg::IR_CAPTURE;
         end else if (in_sir) begin
            ir_shift <= {i_tdi, ir_shift[bst_pkg::IR_W-1:1]};
         end
         if (state == bst_pkg::BST_UIR) begin
            ir <= ir_shift;
         end
         if (state == bst_pkg::BST_CDR) begin
            id_shift   <= ID_CODE;
            user_shift <= user_reg ^ user_capture_q;
            bypass_bit <= 1'b0;
         end else if (in_sdr) begin
            id_shift   <= {i_tdi, id_shift[bst_pkg::ID_W-1:1]};
            user_shift <= {i_tdi, user_shift[USER_WIDTH-1:1]};
            bypass_bit <= i_tdi;
         end
         if (state == bst_pkg::BST_UDR && sel_user) begin
            user_reg <= user_shift;
            user_tgl <= ~user_tgl;
         end
      end
   end

   // capture input is static system data; sampled into tck domain
   always_ff @(posedge i_tck) begin
      user_capture_m <= i_user_capture;
      user_capture_q <= user_capture_m;
   end

   // ****************************************
   // output stage on falling tck
   // ****************************************
   wire dr_bit  = sel_id ? id_shift[0] : (sel_user ? user_shift[0] : bypass_bit);
   wire scan_bit = in_sir ? ir_shift[0] : dr_bit;

   logic tdo_q;
   logic scan_active;

   always_ff @(negedge i_tck or negedge i_trst) begin
      if (!i_trst) begin
         tdo_q       <= 1'b0;
         scan_active <= 1'b0;
      end else begin
         tdo_q       <= scan_bit;
         scan_active <= in_sir || in_sdr;
      end
   end

   // ****************************************
   // system domain: crossings and outputs
   // ****************************************
   // off condition is asynchronous to both clocks; pins pass two flops
   logic [4:0] pins_s;

   bst_sync #(
      .W (5)
   ) u_sync (
      .i_clk (i_clk_sys),
      .i_rst (i_rst),
      .i_d   ({i_trst, i_emulator_line_a, i_emulator_line_b_or_disable,
               scan_active, user_tgl}),
      .o_q   (pins_s)
   );

   wire trst_s    = pins_s[4];
   wire line_a_s  = pins_s[3];
   wire line_b_s  = pins_s[2];
   wire active_s  = pins_s[1];
   wire tgl_s     = pins_s[0];
   wire off_cond  = !trst_s && line_a_s && !line_b_s;

   logic tgl_seen;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_outputs_off <= 1'b0;
         tgl_seen      <= 1'b0;
         o_user_update <= 1'b0;
         o_user_data   <= bst_pkg::USER_RST;
      end else begin
         o_outputs_off <= off_cond;
         tgl_seen      <= tgl_s;
         o_user_update <= tgl_s ^ tgl_seen;
         if (tgl_s ^ tgl_seen) begin
            o_user_data <= user_reg; // stable since toggle settled two flops ago
         end
      end
   end

   // tdo must keep tck timing, so data and enable stay on the falling-edge flops;
   // the off condition gates the enable directly, not through the sync, to act at once
   wire raw_off = !i_trst && i_emulator_line_a && !i_emulator_line_b_or_disable;

   always_comb begin
      o_tdo    = tdo_q;
      o_tdo_oe = scan_active && i_trst && !raw_off;
   end

endmodule

// File: bst_tap_assertions.sv
// checker for the test access port pins
module bst_tap_checker #(parameter int USER_WIDTH = 16) (
   input wire logic                  i_clk_sys,
   input wire logic                  i_rst,
   input wire logic                  i_tck,
   input wire logic                  i_tms,
   input wire logic                  i_trst,
   input wire logic                  i_emulator_line_a,
   input wire logic                  i_emulator_line_b_or_disable,
   input wire logic                  o_tdo,
   input wire logic                  o_tdo_oe,
   input wire logic                  o_outputs_off,
   input wire logic [USER_WIDTH-1:0] o_user_data,
   input wire logic                  o_user_update
);
   // ****
   // pin properties
   // ****
   wire logic off_c = !i_trst && i_emulator_line_a && !i_emulator_line_b_or_disable;
   logic      seen;
   logic      tdo_r;
   // seen blocks a stale tdo_r right after test reset
   always_ff @(posedge i_tck or negedge i_trst) begin
      if (!i_trst) begin
         seen  <= 1'b0;
         tdo_r <= 1'b0;
      end else begin
         seen <= 1'b1;
         tdo_r <= o_tdo;
      end
   end
   off_hiz_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) off_c |-> !o_tdo_oe)
      else $error("tdo driven while off");
   trst_hiz_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) !i_trst |-> !o_tdo_oe)
      else $error("tdo driven in test reset");
   off_set_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) off_c [*4] |-> o_outputs_off)
      else $error("off flag late");
   off_clr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) !off_c [*4] |-> !o_outputs_off)
      else $error("off flag stuck");
   oe_shift_a: assert property (@(posedge i_tck) disable iff (!i_trst) o_tdo_oe |-> !$past(i_tms))
      else $error("tdo driven outside shift");
   tdo_fall_a: assert property (@(negedge i_tck) disable iff (!i_trst) seen |-> o_tdo == tdo_r)
      else $error("tdo moved after rising edge");
   upd_pulse_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) o_user_update |=> !o_user_update)
      else $error("update pulse too long");
   cover property (@(posedge i_clk_sys) o_outputs_off);
   cover property (@(posedge i_clk_sys) o_user_update);
   cover property (@(posedge i_tck) o_tdo_oe);
endmodule
bind bst_tap bst_tap_checker #(.USER_WIDTH(USER_WIDTH)) u_chk (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_tck(i_tck), .i_tms(i_tms), .i_trst(i_trst),
   .i_emulator_line_a(i_emulator_line_a),
   .i_emulator_line_b_or_disable(i_emulator_line_b_or_disable),
   .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_outputs_off(o_outputs_off),
   .o_user_data(o_user_data), .o_user_update(o_user_update));

// File: test_boundary_scan_test_port.sv
// testbench for the test access port
module test_boundary_scan_test_port;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_sys, rst, line_a, line_b, tck, tms, tdi, trst, tdo, oe, off, upd;
   logic [15:0] cap, udata;
   int          bad_count = 0, checks_done = 0, cycles = 0;
   bst_ctrl_model M (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst(trst),
      .i_tdo(tdo), .i_tdo_oe(oe));
   bst_tap #(.USER_WIDTH(16), .ID_CODE(bst_pkg::ID_VAL)) DUT (.i_clk_sys(clk_sys),
      .i_rst(rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_trst(trst),
      .i_emulator_line_a(line_a), .i_emulator_line_b_or_disable(line_b),
      .i_user_capture(cap), .o_tdo(tdo), .o_tdo_oe(oe), .o_outputs_off(off),
      .o_user_data(udata), .o_user_update(upd));
   // ****
   // checks and scenarios
   // ****
   task automatic conclude();
      if (bad_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_upd();
      int k;
      for (k = 0; k < 20 && upd !== 1'b1; k++) begin
         @(negedge clk_sys);
      end
      chk(k < 20, 1'b1);
      @(negedge clk_sys);
   endtask
   task automatic t_scans();
      logic [31:0] q;
      M.scan(1'b1, 4, 32'h1, q);
      chk(q[3:0], bst_pkg::IR_CAPTURE);
      M.scan(1'b0, 32, '1, q);
      chk(q, bst_pkg::ID_VAL);
      chk(oe, 1'b0);
      M.scan(1'b1, 4, 32'h2, q);
      M.scan(1'b0, 16, 32'hA5C3, q);
      wait_upd();
      chk(udata, 16'hA5C3);
      cap = 16'h00FF;
      M.scan(1'b0, 16, 32'h1234, q);
      chk(q[15:0], 16'hA5C3 ^ 16'h00FF);
      wait_upd();
      chk(udata, 16'h1234);
      M.tap_reset();
      M.scan(1'b0, 32, '0, q);
      chk(q, bst_pkg::ID_VAL);
      M.scan(1'b1, 4, 32'hF, q);
      M.scan(1'b0, 2, 32'h3, q);
      chk(q[1:0], 2'b10);
   endtask
   task automatic t_off();
      line_a = 1'b1;
      line_b = 1'b0;
      M.set_trst(1'b0);
      repeat (4) @(negedge clk_sys);
      chk(off, 1'b1);
      chk(oe, 1'b0);
      M.set_trst(1'b1);
      line_b = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk(off, 1'b0);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      rst = 1'b1;
      line_a = 1'b0;
      line_b = 1'b1;
      cap = 16'h0000;
      repeat (10) @(negedge clk_sys);
      rst = 1'b0;
      M.tap_reset();
      t_scans();
      @(negedge clk_sys);
      t_off();
      conclude();
   end
endmodule
